// ### include/ptm_pkg.sv
// Package for the 10-bit periodic timer register block
package ptm_pkg;
   localparam int          PTM_CW          = 10;
   localparam int          PTM_AW          = 4;
   localparam logic [3:0]  ADR_CTRL        = 4'h0;
   localparam logic [3:0]  ADR_CNT_LO      = 4'h1;
   localparam logic [3:0]  ADR_CNT_HI      = 4'h2;
   localparam logic [3:0]  ADR_CMPA_LO     = 4'h3;
   localparam logic [3:0]  ADR_CMPA_HI     = 4'h4;
   localparam logic [3:0]  ADR_PER_LO      = 4'h5;
   localparam logic [3:0]  ADR_PER_HI      = 4'h6;
   localparam logic [3:0]  ADR_RUN         = 4'h7;
   localparam logic [7:0]  CTRL_RST        = 8'h00;
   localparam int          RUN_ON_BIT      = 3;
   localparam logic [9:0]  CNT_MAX         = 10'h3FF;
   localparam logic [1:0]  PF_NOCHG        = 2'h0;
   localparam logic [1:0]  PF_LOW          = 2'h1;
   localparam logic [1:0]  PF_HIGH         = 2'h2;
   localparam logic [1:0]  PF_TOGGLE       = 2'h3;

   typedef enum logic [1:0] {
      PTM_MODE_CMP = 2'b00,
      PTM_MODE_CAP = 2'b01,
      PTM_MODE_PWM = 2'b10,
      PTM_MODE_TMR = 2'b11
   } ptm_mode_t;

   // Control register layout, bit 7 down to bit 0
   typedef struct packed {
      ptm_mode_t  mode_sel;
      logic [1:0] pin_func;
      logic       output_init_level;
      logic       output_invert;
      logic       reserved_d1;
      logic       clear_source_sel;
   } ptm_ctrl_t;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } ptm_bus_req_t;
endpackage : ptm_pkg

// ### hw/ptm_timer.sv
// Register set, counter, comparators and output pin of the 10-bit periodic timer
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
module ptm_timer
   import ptm_pkg::*;
#(
   parameter int CW = PTM_CW
) (
   input  wire logic             clk_sys_i,
   input  wire logic             sys_rst_i,
   input  wire logic [3:0]       reg_addr_i,
   input  wire logic [7:0]       reg_wdata_i,
   input  wire logic             reg_wr_i,
   input  wire logic             reg_rd_i,
   input  wire logic             tick_i,
   output logic [7:0]            reg_rdata_o,
   output logic                  timer_output_pin_o,
   output logic                  compare_a_flag_o,
   output logic                  compare_p_flag_o
);
   //////////////////////////////////////////////////////////////////////////////
   ptm_bus_req_t    bus;
   ptm_ctrl_t       ctrl_q;
   logic            timer_on_q;
   logic            timer_on_prev_q;
   logic [CW-1:0]   cnt_q;
   logic [CW-1:0]   compare_a_value_q;
   logic [CW-1:0]   period_compare_value_q;
   logic            pin_q;
   logic            match_a;
   logic            match_p;
   logic            on_rise;
   logic            cnt_clear;
   logic            pwm_mode;
   logic            spulse;
   logic            duty_active;
   logic            raw_level;
   logic            pulse_stop;
   logic [CW-1:0]   p_target;

   assign bus = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

   function automatic logic is_wr(input ptm_bus_req_t b, input logic [3:0] a);
      return b.wr && (b.addr == a);
   endfunction : is_wr

   //////////////////////////////////////////////////////////////////////////////
   // Register writes; reserved bit 1 is stored as written (software keeps it)
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         ctrl_q <= ptm_ctrl_t'(CTRL_RST);
      end else if (is_wr(bus, ADR_CTRL)) begin
         ctrl_q <= ptm_ctrl_t'(bus.wdata);
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         compare_a_value_q      <= '0;
         period_compare_value_q <= '0;
      end else begin
         if (is_wr(bus, ADR_CMPA_LO)) compare_a_value_q[7:0]      <= bus.wdata;
         if (is_wr(bus, ADR_CMPA_HI)) compare_a_value_q[CW-1:8]   <= bus.wdata[CW-9:0];
         if (is_wr(bus, ADR_PER_LO))  period_compare_value_q[7:0] <= bus.wdata;
         if (is_wr(bus, ADR_PER_HI))  period_compare_value_q[CW-1:8] <= bus.wdata[CW-9:0];
      end
   end

   // Single pulse ends by clearing the on bit on an A match; a run register write in the same cycle wins
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         timer_on_q <= 1'b0;
      end else if (is_wr(bus, ADR_RUN)) begin
         timer_on_q <= bus.wdata[RUN_ON_BIT];
      end else if (pulse_stop) begin
         timer_on_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) timer_on_prev_q <= 1'b0;
      else           timer_on_prev_q <= timer_on_q;
   end

   //////////////////////////////////////////////////////////////////////////////
   // Comparators and counter
   assign on_rise  = timer_on_q && !timer_on_prev_q;
   assign pwm_mode = (ctrl_q.mode_sel == PTM_MODE_PWM);
   assign spulse   = pwm_mode && (ctrl_q.pin_func == PF_TOGGLE);
   // PWM matches one count early so the period is P counts; zero lands on full scale (1024)
   assign p_target = pwm_mode ? (period_compare_value_q - 1'b1) : period_compare_value_q;
   // The switch-on cycle still holds the stale count, so no match may come from it
   assign match_a  = timer_on_q && !on_rise && tick_i && (cnt_q == compare_a_value_q);
   assign match_p  = timer_on_q && !on_rise && tick_i && (cnt_q == p_target)
                     && !(ctrl_q.clear_source_sel && !pwm_mode);
   assign pulse_stop = spulse && match_a;

   always_comb begin
      cnt_clear = 1'b0;
      if (pwm_mode) begin
         cnt_clear = !spulse && match_p;
      end else if (ctrl_q.clear_source_sel) begin
         cnt_clear = match_a;
      end else begin
         cnt_clear = match_p && (period_compare_value_q != '0);
      end
   end

   // Zero period lets the counter wrap at full scale, which gives 1024 counts
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         cnt_q <= '0;
      end else if (on_rise) begin
         cnt_q <= '0;
      end else if (timer_on_q && tick_i) begin
         if (cnt_clear) cnt_q <= '0;
         else           cnt_q <= cnt_q + 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         compare_a_flag_o <= 1'b0;
         compare_p_flag_o <= 1'b0;
      end else begin
         compare_a_flag_o <= match_a;
         compare_p_flag_o <= match_p;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Output pin
   assign duty_active = (cnt_q < compare_a_value_q)
                        || ((compare_a_value_q >= period_compare_value_q) && (period_compare_value_q != '0));

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         pin_q <= 1'b0;
      end else if (on_rise) begin
         pin_q <= ctrl_q.output_init_level;
      end else if (ctrl_q.mode_sel == PTM_MODE_CMP && match_a) begin
         case (ctrl_q.pin_func)
            PF_LOW:    pin_q <= 1'b0;
            PF_HIGH:   pin_q <= 1'b1;
            PF_TOGGLE: pin_q <= !pin_q;
            default:   pin_q <= pin_q;
         endcase
      end else if (spulse && pulse_stop) begin
         pin_q <= !ctrl_q.output_init_level;
      end
   end

   always_comb begin
      raw_level = pin_q;
      if (pwm_mode) begin
         case (ctrl_q.pin_func)
            PF_NOCHG:  raw_level = !ctrl_q.output_init_level;
            PF_LOW:    raw_level = ctrl_q.output_init_level;
            PF_HIGH:   raw_level = (timer_on_q && duty_active) ? ctrl_q.output_init_level
                                                               : !ctrl_q.output_init_level;
            default:   raw_level = timer_on_q ? pin_q : !ctrl_q.output_init_level;
         endcase
      end
   end

   // Timer mode leaves the pin undefined; it is held low here
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         timer_output_pin_o <= 1'b0;
      end else if (ctrl_q.mode_sel == PTM_MODE_TMR || ctrl_q.mode_sel == PTM_MODE_CAP) begin
         timer_output_pin_o <= 1'b0;
      end else begin
         timer_output_pin_o <= raw_level ^ ctrl_q.output_invert;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Read port, data in the cycle after the strobe, zero otherwise
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i || !bus.rd) begin
         reg_rdata_o <= 8'h00;
      end else begin
         case (bus.addr)
            ADR_CTRL:    reg_rdata_o <= ctrl_q;
            ADR_CNT_LO:  reg_rdata_o <= cnt_q[7:0];
            ADR_CNT_HI:  reg_rdata_o <= {6'h00, cnt_q[CW-1:8]};
            ADR_CMPA_LO: reg_rdata_o <= compare_a_value_q[7:0];
            ADR_CMPA_HI: reg_rdata_o <= {6'h00, compare_a_value_q[CW-1:8]};
            ADR_PER_LO:  reg_rdata_o <= period_compare_value_q[7:0];
            ADR_PER_HI:  reg_rdata_o <= {6'h00, period_compare_value_q[CW-1:8]};
            ADR_RUN:     reg_rdata_o <= {4'h0, timer_on_q, 3'h0};
            default:     reg_rdata_o <= 8'h00;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   a_on_clears_cnt: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      on_rise |=> (cnt_q == '0)) else $error("counter not cleared on switch on");
   a_on_init_pin: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      on_rise && ctrl_q.mode_sel == PTM_MODE_CMP |=> pin_q == $past(ctrl_q.output_init_level))
      else $error("pin not at initial level");
   a_cmp_high: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      match_a && !on_rise && ctrl_q.mode_sel == PTM_MODE_CMP && ctrl_q.pin_func == PF_HIGH |=> pin_q)
      else $error("pin not high after match");
   a_cmp_toggle: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      match_a && !on_rise && ctrl_q.mode_sel == PTM_MODE_CMP && ctrl_q.pin_func == PF_TOGGLE
      |=> pin_q != $past(pin_q)) else $error("pin did not toggle");
   a_p_no_pin: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      match_p && !match_a && !on_rise && ctrl_q.mode_sel == PTM_MODE_CMP |=> $stable(pin_q))
      else $error("P match moved pin");
   a_clr_a_sel: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      match_a && !pwm_mode && ctrl_q.clear_source_sel |=> cnt_q == '0) else $error("A match no clear");
   a_no_ovf_clr: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      timer_on_q && tick_i && !on_rise && !cnt_clear && cnt_q != CNT_MAX |=> cnt_q == $past(cnt_q) + 1'b1)
      else $error("counter failed to advance");
   a_hi_zero: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      bus.rd && bus.addr == ADR_CNT_HI |=> reg_rdata_o[7:2] == 6'h00) else $error("high bits not zero");
   a_invert: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      ctrl_q.mode_sel == PTM_MODE_CMP && $stable(ctrl_q)
      |=> timer_output_pin_o == ($past(pin_q) ^ $past(ctrl_q.output_invert)))
      else $error("polarity wrong");

   //////////////////////////////////////////////////////////////////////////////
   // Step sequences shared by the properties below
   sequence s_switch_on;
      on_rise;
   endsequence

   sequence s_cmp_a_hit;
      match_a && !on_rise && (ctrl_q.mode_sel == PTM_MODE_CMP);
   endsequence

   sequence s_pulse_end;
      pulse_stop && !is_wr(bus, ADR_RUN);
   endsequence

   a_cmp_low: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      s_cmp_a_hit ##0 (ctrl_q.pin_func == PF_LOW) |=> !pin_q)
      else $error("pin not low after match");

   a_cmp_nochg: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      s_cmp_a_hit ##0 (ctrl_q.pin_func == PF_NOCHG) |=> $stable(pin_q))
      else $error("pin moved with no change selected");

   a_pulse_stop: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      s_pulse_end |=> !timer_on_q)
      else $error("single pulse did not stop timer");

   a_pulse_level: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      s_pulse_end |=> pin_q == !$past(ctrl_q.output_init_level))
      else $error("pulse trailing level wrong");

   a_sp_init: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      s_switch_on ##0 spulse |=> pin_q == $past(ctrl_q.output_init_level))
      else $error("pulse leading level wrong");

   a_flag_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      match_a |=> compare_a_flag_o)
      else $error("A flag missing");

   a_flag_p: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      match_p |=> compare_p_flag_o)
      else $error("P flag missing");

   a_flag_a_off: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      !timer_on_q |=> !compare_a_flag_o)
      else $error("A flag while off");

   a_flag_p_off: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      !timer_on_q |=> !compare_p_flag_o)
      else $error("P flag while off");

   a_no_p_flag: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      ctrl_q.clear_source_sel && !pwm_mode |=> !compare_p_flag_o)
      else $error("P flag with A clear selected");

   a_p_clear: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      match_p && !pwm_mode && !ctrl_q.clear_source_sel && period_compare_value_q != '0 |=> cnt_q == '0)
      else $error("P match no clear");

   a_per_zero: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      match_p && !pwm_mode && period_compare_value_q == '0 && cnt_q != CNT_MAX |=> cnt_q == $past(cnt_q) + 1'b1)
      else $error("zero period cleared counter");

   a_ovf_wrap: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      timer_on_q && tick_i && !on_rise && !cnt_clear && cnt_q == CNT_MAX |=> cnt_q == '0)
      else $error("counter did not wrap");

   a_pwm_clear: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      pwm_mode && !spulse && match_p |=> cnt_q == '0)
      else $error("pwm period not restarted");

   a_cnt_hold: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      !timer_on_q |=> $stable(cnt_q))
      else $error("counter moved while off");

   a_tmr_pin: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      ctrl_q.mode_sel == PTM_MODE_TMR || ctrl_q.mode_sel == PTM_MODE_CAP |=> !timer_output_pin_o)
      else $error("pin driven in timer mode");

   a_pwm_inactive: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      pwm_mode && ctrl_q.pin_func == PF_NOCHG
      |=> timer_output_pin_o == (!$past(ctrl_q.output_init_level) ^ $past(ctrl_q.output_invert)))
      else $error("forced inactive level wrong");

   a_pwm_active: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      pwm_mode && ctrl_q.pin_func == PF_LOW
      |=> timer_output_pin_o == ($past(ctrl_q.output_init_level) ^ $past(ctrl_q.output_invert)))
      else $error("forced active level wrong");

   a_pwm_below: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      pwm_mode && ctrl_q.pin_func == PF_HIGH && timer_on_q && cnt_q < compare_a_value_q
      |=> timer_output_pin_o == ($past(ctrl_q.output_init_level) ^ $past(ctrl_q.output_invert)))
      else $error("pwm not active before duty");

   a_pwm_above: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      pwm_mode && ctrl_q.pin_func == PF_HIGH && timer_on_q && cnt_q >= compare_a_value_q
      && compare_a_value_q < period_compare_value_q
      |=> timer_output_pin_o == (!$past(ctrl_q.output_init_level) ^ $past(ctrl_q.output_invert)))
      else $error("pwm active after duty");

   a_pwm_full: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      pwm_mode && ctrl_q.pin_func == PF_HIGH && timer_on_q && period_compare_value_q != '0
      && compare_a_value_q >= period_compare_value_q
      |=> timer_output_pin_o == ($past(ctrl_q.output_init_level) ^ $past(ctrl_q.output_invert)))
      else $error("full duty not held");

   a_ctrl_write: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      is_wr(bus, ADR_CTRL) |=> ctrl_q == $past(bus.wdata))
      else $error("control write lost");

   a_wr_a_lo: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      is_wr(bus, ADR_CMPA_LO) |=> compare_a_value_q[7:0] == $past(bus.wdata))
      else $error("compare A low write lost");

   a_wr_a_hi: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      is_wr(bus, ADR_CMPA_HI) |=> compare_a_value_q[CW-1:8] == $past(bus.wdata[1:0]))
      else $error("compare A high write lost");

   a_wr_p_lo: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      is_wr(bus, ADR_PER_LO) |=> period_compare_value_q[7:0] == $past(bus.wdata))
      else $error("period low write lost");

   a_wr_p_hi: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      is_wr(bus, ADR_PER_HI) |=> period_compare_value_q[CW-1:8] == $past(bus.wdata[1:0]))
      else $error("period high write lost");

   a_rd_idle: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      !bus.rd |=> reg_rdata_o == 8'h00)
      else $error("read data outside read cycle");

   a_rd_ctrl: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      bus.rd && bus.addr == ADR_CTRL |=> reg_rdata_o == $past(ctrl_q))
      else $error("control read wrong");

   a_rd_cnt_lo: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      bus.rd && bus.addr == ADR_CNT_LO |=> reg_rdata_o == $past(cnt_q[7:0]))
      else $error("counter low read wrong");

   a_rd_a_hi: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      bus.rd && bus.addr == ADR_CMPA_HI |=> reg_rdata_o[7:2] == 6'h00)
      else $error("compare A high bits not zero");

   a_rd_p_hi: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      bus.rd && bus.addr == ADR_PER_HI |=> reg_rdata_o[7:2] == 6'h00)
      else $error("period high bits not zero");

   a_rd_unmapped: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      bus.rd && bus.addr > ADR_RUN |=> reg_rdata_o == 8'h00)
      else $error("unmapped read not zero");
endmodule : ptm_timer
`default_nettype wire

// ### test/tb_ptm_timer.sv
// Self-checking testbench for the 10-bit periodic timer register block
`timescale 1ns/1ns
`default_nettype none
module tb_ptm_timer
   import ptm_pkg::*;
();
   logic       clk_sys_i = 1'b0;
   logic       sys_rst_i = 1'b1;
   logic [3:0] reg_addr_i = 4'h0;
   logic [7:0] reg_wdata_i = 8'h00;
   logic       reg_wr_i = 1'b0;
   logic       reg_rd_i = 1'b0;
   logic       tick_i = 1'b1;
   logic [7:0] reg_rdata_o;
   logic       timer_output_pin_o;
   logic       compare_a_flag_o;
   logic       compare_p_flag_o;
   int         err_count = 0;
   int         check_count = 0;
   int         cyc = 0;
   ptm_timer uut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .tick_i(tick_i),
      .reg_rdata_o(reg_rdata_o), .timer_output_pin_o(timer_output_pin_o),
      .compare_a_flag_o(compare_a_flag_o), .compare_p_flag_o(compare_p_flag_o));
   always #20 clk_sys_i = ~clk_sys_i;
   //////////////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      $display("Checks made: %0d, mismatches: %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : complete_run
   // Whole run needs about 2000 cycles; the ceiling leaves ample margin
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         complete_run();
      end
   end
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // A one-cycle gap follows every strobe so no strobe is assigned twice in a step
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      @(posedge clk_sys_i);
      reg_wr_i    <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      @(posedge clk_sys_i);
      reg_rd_i   <= 1'b0;
      @(negedge clk_sys_i);
      d = reg_rdata_o;
   endtask : rd
   task automatic rd_chk(input string what, input logic [3:0] a, input logic [7:0] e);
      logic [7:0] v;
      rd(a, v);
      chk(what, {8'h00, e}, {8'h00, v});
   endtask : rd_chk
   task automatic wr10(input logic [3:0] a, input logic [9:0] v);
      wr(a, v[7:0]);
      wr(a + 4'h1, {6'h00, v[9:8]});
   endtask : wr10
   task automatic run(input ptm_ctrl_t c);
      wr(ADR_RUN, 8'h00);
      wr(ADR_CTRL, c);
      wr(ADR_RUN, 8'h08);
   endtask : run
   task automatic cycles(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask : cycles
   task automatic count_ev(input int n, output int na, output int np, output int nh);
      na = 0;
      np = 0;
      nh = 0;
      repeat (n) begin
         @(negedge clk_sys_i);
         na += (compare_a_flag_o === 1'b1);
         np += (compare_p_flag_o === 1'b1);
         nh += (timer_output_pin_o === 1'b1);
      end
   endtask : count_ev
   task automatic wait_a(output int n);
      n = 0;
      do begin
         @(negedge clk_sys_i);
         n++;
      end while (compare_a_flag_o !== 1'b1 && n < 1100);
   endtask : wait_a
   task automatic clr_case(input ptm_mode_t m, input logic clr, input logic ea, input logic ep);
      ptm_ctrl_t c;
      int        na, np, nh;
      c = CTRL_RST;
      c.mode_sel = m;
      c.pin_func = (m == PTM_MODE_PWM) ? PF_HIGH : PF_NOCHG;
      c.clear_source_sel = clr;
      run(c);
      count_ev(40, na, np, nh);
      chk("compare a seen", {15'h0000, ea}, {15'h0000, na > 0});
      chk("compare p seen", {15'h0000, ep}, {15'h0000, np > 0});
   endtask : clr_case
   //////////////////////////////////////////////////////////////////////////////
   initial begin
      ptm_ctrl_t  c;
      logic       lvl;
      logic [7:0] v1, v2;
      logic [9:0] duty [6] = '{10'h003, 10'h003, 10'h003, 10'h008, 10'h003, 10'h003};
      logic [1:0] pfs  [6] = '{PF_HIGH, PF_HIGH, PF_HIGH, PF_HIGH, PF_NOCHG, PF_LOW};
      logic [1:0] ocinv[6] = '{2'h2, 2'h0, 2'h3, 2'h2, 2'h2, 2'h2};
      int         hi   [6] = '{12, 20, 20, 32, 0, 32};
      int         n, na, np, nh;
      repeat (2) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      for (int i = 0; i < 9; i++) rd_chk("reset value", 4'(i), 8'h00);
      for (int i = 1; i < 7; i++) wr(4'(i), 8'hFF);
      wr(4'hF, 8'hFF);
      rd_chk("counter low", ADR_CNT_LO, 8'h00);
      rd_chk("counter high", ADR_CNT_HI, 8'h00);
      rd_chk("compare a low", ADR_CMPA_LO, 8'hFF);
      rd_chk("compare a high", ADR_CMPA_HI, 8'h03);
      rd_chk("period low", ADR_PER_LO, 8'hFF);
      rd_chk("period high", ADR_PER_HI, 8'h03);
      rd_chk("unmapped", 4'hF, 8'h00);
      wr(ADR_CTRL, 8'hF9);
      rd_chk("control", ADR_CTRL, 8'hF9);
      $display("Test register access done");
      wr10(ADR_CMPA_LO, 10'h005);
      wr10(ADR_PER_LO, 10'h00A);
      for (int i = 0; i < 16; i++) begin
         c = CTRL_RST;
         c.pin_func = 2'(i >> 2);
         c.output_init_level = i[1];
         c.output_invert = i[0];
         run(c);
         cycles(3);
         chk("pin before match", 16'(i[1] ^ i[0]), 16'(timer_output_pin_o));
         wait_a(n);
         cycles(2);
         lvl = (c.pin_func == PF_NOCHG) ? i[1] : (c.pin_func == PF_LOW) ? 1'b0 :
               (c.pin_func == PF_HIGH) ? 1'b1 : !i[1];
         chk("pin after match", 16'(lvl ^ i[0]), 16'(timer_output_pin_o));
         cycles(5);
         chk("pin after p match", 16'(lvl ^ i[0]), 16'(timer_output_pin_o));
      end
      $display("Test compare output done");
      wr10(ADR_CMPA_LO, 10'h006);
      wr10(ADR_PER_LO, 10'h004);
      clr_case(PTM_MODE_CMP, 1'b1, 1'b1, 1'b0);
      clr_case(PTM_MODE_CMP, 1'b0, 1'b0, 1'b1);
      clr_case(PTM_MODE_PWM, 1'b1, 1'b0, 1'b1);
      $display("Test clear source done");
      wr10(ADR_PER_LO, 10'h008);
      for (int i = 0; i < 6; i++) begin
         wr10(ADR_CMPA_LO, duty[i]);
         c = CTRL_RST;
         c.mode_sel = PTM_MODE_PWM;
         c.pin_func = pfs[i];
         {c.output_init_level, c.output_invert} = ocinv[i];
         run(c);
         cycles(10);
         count_ev(32, na, np, nh);
         chk("pwm high cycles", 16'(hi[i]), 16'(nh));
      end
      $display("Test pwm done");
      c = CTRL_RST;
      c.mode_sel = PTM_MODE_PWM;
      c.pin_func = PF_TOGGLE;
      c.output_init_level = 1'b1;
      run(c);
      cycles(3);
      chk("pulse leading", 16'h0001, 16'(timer_output_pin_o));
      wait_a(n);
      cycles(2);
      chk("pulse trailing", 16'h0000, 16'(timer_output_pin_o));
      rd_chk("pulse stops timer", ADR_RUN, 8'h00);
      $display("Test single pulse done");
      // Overflow clear needs a period value of zero, so A matches 1024 ticks apart
      wr10(ADR_CMPA_LO, 10'h005);
      wr10(ADR_PER_LO, 10'h000);
      run(CTRL_RST);
      wait_a(n);
      wait_a(n);
      chk("overflow period", 16'd1024, 16'(n));
      wr(ADR_RUN, 8'h00);
      rd(ADR_CNT_LO, v1);
      cycles(5);
      rd(ADR_CNT_LO, v2);
      chk("held count", {8'h00, v1}, {8'h00, v2});
      wr(ADR_RUN, 8'h08);
      rd(ADR_CNT_LO, v1);
      chk("count restarted", 16'h0001, 16'(v1 <= 8'h03));
      $display("Test counter on and off done");
      complete_run();
   end
endmodule : tb_ptm_timer
`default_nettype wire
